// >>> bsrsa_pkg.sv
// Shared constants and types for the bus state reset and SDRAM area block
package bsrsa_pkg;
    localparam int AREA_NUM = 7;
    localparam int AREA_W = 3;
    localparam int TYPE_W = 3;
    localparam logic [AREA_W-1:0] AREA_SDRAM_LO = 3'h2;
    localparam logic [AREA_W-1:0] AREA_SDRAM_HI = 3'h3;
    localparam logic [TYPE_W-1:0] MEM_TYPE_RESET = 3'h0;
    localparam logic [TYPE_W-1:0] MEM_TYPE_SDRAM = 3'h4;
    localparam int CLK_PERIOD_NS = 50;
    localparam int REFRESH_INTERVAL_NS = 7800;
    localparam int REFRESH_CMP_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
    localparam logic [7:0] REFRESH_CMP = 8'(REFRESH_CMP_CYC);
    localparam logic [7:0] REFRESH_CNT_RESET = 8'h00;
    localparam logic [3:0] ACCESS_CYC = 4'h4;
    localparam logic [3:0] REFRESH_CYC = 4'h6;
    localparam logic [1:0] PIN_SYNC_RESET = 2'h3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACCESS = 2'b01,
        ST_REFRESH = 2'b10,
        ST_GRANT = 2'b11
    } bsrsa_state_t;
endpackage

// >>> bsrsa_rfsh_if.sv
// Refresh request link between refresh timer and bus controller
`timescale 1ns/1ps
interface bsrsa_rfsh_if;
    logic [7:0] cnt;
    logic req;
    logic ack;
    logic mrst_active;
    modport timer (output cnt, output req, input ack, input mrst_active);
    modport ctrl (input cnt, input req, output ack, output mrst_active);
endinterface

// >>> bsrsa_refresh_timer.sv
// Refresh interval counter and refresh request flag
`timescale 1ns/1ps
module bsrsa_refresh_timer
    import bsrsa_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    bsrsa_rfsh_if.timer rf
);
    logic [7:0] refresh_interval_counter_reg;
    logic req_reg;
    logic hit;

    assign hit = (refresh_interval_counter_reg == REFRESH_CMP);
    assign rf.cnt = refresh_interval_counter_reg;
    assign rf.req = req_reg;

    // ****************************************
    // Counter, runs through manual reset
    // ****************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            refresh_interval_counter_reg <= REFRESH_CNT_RESET;
        else if (hit)
            refresh_interval_counter_reg <= REFRESH_CNT_RESET;
        else
            refresh_interval_counter_reg <= refresh_interval_counter_reg + 8'h01; // RULE5
    end

    // Set wins over acknowledge
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            req_reg <= 1'b0;
        else if (hit)
            req_reg <= 1'b1; // RULE6
        else if (rf.ack)
            req_reg <= 1'b0;
    end

    counter_run_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        rf.mrst_active && !hit |=> refresh_interval_counter_reg == $past(refresh_interval_counter_reg) + 8'h01)
        else $error("refresh counter stalled during manual reset");
    refresh_req_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        hit |=> req_reg && refresh_interval_counter_reg == REFRESH_CNT_RESET)
        else $error("refresh condition did not raise request");
endmodule

// >>> bsrsa_top.sv
// Bus state controller: SDRAM area setup, manual reset handling, refresh and arbitration
// How it works
// [RULE1] Memory type SDRAM is accepted only for areas 2 and 3.
// [RULE2] Software places a single SDRAM in area 3, never area 2 alone.
// [RULE3] Standby, sleep and manual reset leave control registers unchanged.
// [RULE4] Manual reset lets the running bus cycle finish, then accesses wait.
// [RULE5] Refresh interval counter keeps counting while manual reset is asserted.
// [RULE6] Refresh condition during manual reset raises a request and runs refresh.
// [RULE7] External bus requests are ignored and never granted during manual reset; a grant already held when it starts stays until the request drops.
`timescale 1ns/1ps
module bsrsa_top
    import bsrsa_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic manual_reset_in_n,
    input wire logic external_bus_request_in_n,
    input wire logic sleep_in,
    input wire logic standby_in,
    input wire logic cfg_we,
    input wire logic [AREA_W-1:0] cfg_area,
    input wire logic [TYPE_W-1:0] cfg_type,
    input wire logic acc_req,
    input wire logic [AREA_W-1:0] acc_area,
    output logic acc_ack,
    output logic bus_cycle_active,
    output logic cycle_is_sdram,
    output logic refresh_cycle_active,
    output logic bus_grant_out,
    output logic manual_reset_active,
    output logic cfg_rejected,
    output logic [AREA_NUM*TYPE_W-1:0] area_type_out,
    output logic [7:0] refresh_interval_counter_out
);
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] sync3_reg;
    logic [1:0] pin_reg;
    logic mrst_active;
    logic ext_req_active;
    logic [TYPE_W-1:0] area_type_reg [AREA_NUM];
    logic cfg_bad;
    logic cfg_rejected_reg;
    bsrsa_state_t state_reg;
    bsrsa_state_t state_next;
    logic [3:0] phase_reg;
    logic cycle_is_sdram_reg;
    logic access_ok;

    bsrsa_rfsh_if rf();

    bsrsa_refresh_timer u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .rf(rf)
    );

    // ****************************************
    // Pin synchronisers, bit 1 manual reset, bit 0 bus request
    // ****************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_reg <= PIN_SYNC_RESET;
            sync2_reg <= PIN_SYNC_RESET;
            sync3_reg <= PIN_SYNC_RESET;
        end
        else
        begin
            sync1_reg <= {manual_reset_in_n, external_bus_request_in_n};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pin
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    pin_reg[gi] <= PIN_SYNC_RESET[gi];
                else if (sync2_reg[gi] == sync3_reg[gi])
                    pin_reg[gi] <= sync3_reg[gi];
            end
        end
    endgenerate

    assign mrst_active = !pin_reg[1];
    assign ext_req_active = !pin_reg[0];
    assign rf.mrst_active = mrst_active;

    // ****************************************
    // Area memory type registers, cleared only by power-on reset
    // ****************************************
    assign cfg_bad = (cfg_type == MEM_TYPE_SDRAM)
        && (cfg_area != AREA_SDRAM_LO) && (cfg_area != AREA_SDRAM_HI);

    generate
        for (gi = 0; gi < AREA_NUM; gi++)
        begin : g_area
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    area_type_reg[gi] <= MEM_TYPE_RESET;
                else if (cfg_we && !cfg_bad && cfg_area == AREA_W'(gi))
                    area_type_reg[gi] <= cfg_type; // RULE1 RULE3
            end
            assign area_type_out[gi*TYPE_W +: TYPE_W] = area_type_reg[gi];
            if (gi != 2 && gi != 3)
            begin : g_chk
                never_sdram_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
                    area_type_reg[gi] != MEM_TYPE_SDRAM)
                    else $error("SDRAM type held outside areas 2 and 3");
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cfg_rejected_reg <= 1'b0;
        else
            cfg_rejected_reg <= cfg_we && cfg_bad; // RULE1
    end

    // ****************************************
    // Bus cycle sequencer
    // ****************************************
    assign access_ok = acc_req && !mrst_active && !sleep_in && !standby_in;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (rf.req)
                    state_next = ST_REFRESH; // RULE6
                else if (ext_req_active && !mrst_active)
                    state_next = ST_GRANT; // RULE7
                else if (access_ok)
                    state_next = ST_ACCESS; // RULE4
            end
            ST_ACCESS:
            begin
                if (phase_reg == 4'h0)
                    state_next = ST_IDLE;
            end
            ST_REFRESH:
            begin
                if (phase_reg == 4'h0)
                    state_next = ST_IDLE;
            end
            ST_GRANT:
            begin
                if (!ext_req_active)
                    state_next = ST_IDLE;
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Remaining cycles of the running access or refresh
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            phase_reg <= 4'h0;
        else if (state_reg == ST_IDLE && state_next == ST_ACCESS)
            phase_reg <= ACCESS_CYC - 4'h1;
        else if (state_reg == ST_IDLE && state_next == ST_REFRESH)
            phase_reg <= REFRESH_CYC - 4'h1;
        else if (phase_reg != 4'h0)
            phase_reg <= phase_reg - 4'h1; // RULE4
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cycle_is_sdram_reg <= 1'b0;
        else if (state_reg == ST_IDLE && state_next == ST_ACCESS)
            cycle_is_sdram_reg <= (acc_area < AREA_W'(AREA_NUM))
                && (area_type_reg[acc_area] == MEM_TYPE_SDRAM);
    end

    assign rf.ack = (state_reg == ST_IDLE) && (state_next == ST_REFRESH);
    assign acc_ack = (state_reg == ST_ACCESS) && (phase_reg == 4'h0);
    assign bus_cycle_active = (state_reg == ST_ACCESS);
    assign refresh_cycle_active = (state_reg == ST_REFRESH);
    assign bus_grant_out = (state_reg == ST_GRANT);
    assign cycle_is_sdram = cycle_is_sdram_reg;
    assign manual_reset_active = mrst_active;
    assign cfg_rejected = cfg_rejected_reg;
    assign refresh_interval_counter_out = rf.cnt;

    // ****************************************
    // Checks
    // ****************************************
    cfg_reject_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
        cfg_we && cfg_bad |=> cfg_rejected_reg && $stable(area_type_out))
        else $error("SDRAM type accepted for a forbidden area");
    cfg_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
        !cfg_we |=> $stable(area_type_out))
        else $error("area configuration changed without a write");
    cycle_finish_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
        state_reg == ST_ACCESS && phase_reg != 4'h0 && mrst_active
        |=> state_reg == ST_ACCESS && phase_reg == $past(phase_reg) - 4'h1)
        else $error("bus cycle cut short by manual reset");
    access_wait_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
        state_reg == ST_IDLE && mrst_active |=> state_reg != ST_ACCESS)
        else $error("new access started during manual reset");
    refresh_run_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        state_reg == ST_IDLE && rf.req && mrst_active
        |=> refresh_cycle_active [*6] ##1 !refresh_cycle_active)
        else $error("refresh cycle not run during manual reset");
    no_grant_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
        mrst_active && state_reg != ST_GRANT |=> !bus_grant_out)
        else $error("bus granted during manual reset");
endmodule

// >>> bsrsa_ext_master.sv
// External bus master model that asks for the bus on command
`timescale 1ns/1ps
module bsrsa_ext_master (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic want,
    output logic external_bus_request_in_n
);
    // Request line follows the command one edge later, held until dropped
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            external_bus_request_in_n <= 1'b1;
        end
        else
        begin
            external_bus_request_in_n <= !want;
        end
    end
endmodule

// >>> bsrsa_top_tb.sv
// Self-checking testbench of the bus state reset and SDRAM area block
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp); end end
module bsrsa_top_tb
    import bsrsa_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic mrst_n = 1'b1;
    logic want = 1'b0;
    logic ebr_n;
    logic sleep_in = 1'b0;
    logic standby_in = 1'b0;
    logic cfg_we = 1'b0;
    logic [AREA_W-1:0] cfg_area = 3'h0;
    logic [TYPE_W-1:0] cfg_type = 3'h0;
    logic acc_req = 1'b0;
    logic [AREA_W-1:0] acc_area = 3'h0;
    logic acc_ack, bus_act, is_sdram, rf_act, grant, mr_act, rej;
    logic [AREA_NUM*TYPE_W-1:0] types;
    logic [7:0] cnt;
    int err_count = 0;
    int n_checks = 0;

    always #25 clk = !clk;

    bsrsa_ext_master i_master (.clk(clk), .arst_n(arst_n), .want(want),
        .external_bus_request_in_n(ebr_n));

    bsrsa_top i_dut (.clk(clk), .arst_n(arst_n), .manual_reset_in_n(mrst_n),
        .external_bus_request_in_n(ebr_n), .sleep_in(sleep_in),
        .standby_in(standby_in), .cfg_we(cfg_we), .cfg_area(cfg_area),
        .cfg_type(cfg_type), .acc_req(acc_req), .acc_area(acc_area),
        .acc_ack(acc_ack), .bus_cycle_active(bus_act), .cycle_is_sdram(is_sdram),
        .refresh_cycle_active(rf_act), .bus_grant_out(grant),
        .manual_reset_active(mr_act), .cfg_rejected(rej), .area_type_out(types),
        .refresh_interval_counter_out(cnt));

    // Waits up to n edges for a settled output to be high
    task automatic wait_hi(ref logic s, input int n);
        int i;
        for (i = 0; i < n && s !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
    endtask

    // SDRAM written to every area, then area 2 cleared for a lone SDRAM
    task automatic t_cfg();
        logic ok;
        for (int a = 0; a < AREA_NUM; a++)
        begin
            @(posedge clk);
            cfg_area <= 3'(a);
            cfg_type <= MEM_TYPE_SDRAM;
            cfg_we <= 1'b1;
            @(posedge clk);
            cfg_we <= 1'b0;
            #1;
            ok = (a == 2) || (a == 3);
            `CHK(types[3*a+:3], ok ? MEM_TYPE_SDRAM : MEM_TYPE_RESET)
            `CHK(rej, !ok)
        end
        @(posedge clk);
        cfg_area <= AREA_SDRAM_LO;
        cfg_type <= MEM_TYPE_RESET;
        cfg_we <= 1'b1;
        @(posedge clk);
        cfg_we <= 1'b0;
        #1;
        `CHK(types[8:6], MEM_TYPE_RESET)
        `CHK(types[11:9], MEM_TYPE_SDRAM)
        $display("test cfg done");
    endtask

    // Manual reset arriving with an access in flight
    task automatic t_mrst();
        logic [AREA_NUM*TYPE_W-1:0] kept;
        logic [7:0] prev;
        int acks = 0;
        int busy = 0;
        int grants = 0;
        int rfs = 0;
        logic bad = 1'b0;
        kept = types;
        @(posedge clk);
        acc_area <= AREA_SDRAM_HI;
        acc_req <= 1'b1;
        mrst_n <= 1'b0;
        #1;
        wait_hi(acc_ack, 12);
        `CHK(acc_ack, 1'b1)
        `CHK(bus_act, 1'b1)
        `CHK(is_sdram, 1'b1)
        @(posedge clk);
        acc_req <= 1'b0;
        #1;
        wait_hi(mr_act, 10);
        `CHK(mr_act, 1'b1)
        @(posedge clk);
        acc_req <= 1'b1;
        want <= 1'b1;
        sleep_in <= 1'b1;
        standby_in <= 1'b1;
        #1;
        prev = cnt;
        repeat (200)
        begin
            @(posedge clk);
            sleep_in <= 1'b0;
            standby_in <= 1'b0;
            #1;
            acks += int'(acc_ack === 1'b1);
            busy += int'(bus_act === 1'b1);
            grants += int'(grant === 1'b1);
            rfs += int'(rf_act === 1'b1);
            if (cnt !== prev + 8'h01 && !(cnt === 8'h00 && prev >= REFRESH_CMP - 8'h01))
                bad = 1'b1;
            prev = cnt;
        end
        `CHK(acks, 0)
        `CHK(busy, 0)
        `CHK(grants, 0)
        `CHK(rfs > 0, 1'b1)
        `CHK(bad, 1'b0)
        `CHK(types, kept)
        @(posedge clk);
        mrst_n <= 1'b1;
        #1;
        wait_hi(grant, 20);
        `CHK(grant, 1'b1)
        @(posedge clk);
        want <= 1'b0;
        #1;
        wait_hi(acc_ack, 40);
        `CHK(acc_ack, 1'b1)
        @(posedge clk);
        acc_req <= 1'b0;
        #1;
        `CHK(types, kept)
        $display("test mrst done");
    endtask

    // Sleep then standby, area setup must survive both
    task automatic t_lowpwr();
        logic [AREA_NUM*TYPE_W-1:0] kept;
        kept = types;
        @(posedge clk);
        sleep_in <= 1'b1;
        repeat (10) @(posedge clk);
        sleep_in <= 1'b0;
        standby_in <= 1'b1;
        repeat (10) @(posedge clk);
        standby_in <= 1'b0;
        #1;
        `CHK(types, kept)
        $display("test lowpwr done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #(50 * 3000);
        err_count++;
        end_of_test();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(cnt, REFRESH_CNT_RESET + 8'h01)
        `CHK(types, {AREA_NUM{MEM_TYPE_RESET}})
        `CHK(grant, 1'b0)
        t_cfg();
        t_mrst();
        t_lowpwr();
        end_of_test();
    end
endmodule
